// ==== bench/gim_ctl_model.sv ====
// bus controller model that sends command and data bytes to the decoder
`timescale 1ns/10ps
module gim_ctl_model (
  // clock
  input wire logic clk,
  // bus pins toward the decoder
  output logic atn_n,
  output logic ifc_n,
  output logic eoi_n,
  output logic dav_n,
  output logic [7:0] dio,
  // handshake back from the decoder
  input wire logic ndac_pull
);
  // extra cycles data valid stays low; raised to act as a slow controller
  int hold = 0;

  initial
  begin
    atn_n = 1'b1;
    ifc_n = 1'b1;
    eoi_n = 1'b1;
    dav_n = 1'b1;
    dio = 8'h00;
  end

  // ----------------------------------------
  // byte transfer
  // ----------------------------------------
  // attention held with the byte
  task automatic send(input logic atn, input logic eoi, input logic [7:0] b);
    int i;
    @(posedge clk);
    atn_n <= ~atn;
    eoi_n <= ~eoi;
    dio <= b;
    @(posedge clk);
    dav_n <= 1'b0;
    // acknowledge is looked at mid-cycle, where it has settled
    @(negedge clk);
    // a refused byte never has ndac pulled, so the wait ends at once; it is bounded at 8 cycles
    for (i = 0; i < 8 && ndac_pull; i++)
      @(negedge clk);
    repeat (hold + 2) @(posedge clk);
    dav_n <= 1'b1;
    eoi_n <= 1'b1;
    // released lines must not keep showing the old byte
    dio <= ~b;
    repeat (4) @(posedge clk);
    atn_n <= 1'b1;
    @(negedge clk);
  endtask

  // only the controller drives interface clear
  task automatic clear();
    @(posedge clk);
    ifc_n <= 1'b0;
    repeat (6) @(posedge clk);
    ifc_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
endmodule

// ==== bench/gpib_interface_message_decoder_test.sv ====
// self-checking testbench for the interface message decoder
`timescale 1ns/10ps
`include "gim_defs.svh"
module gpib_interface_message_decoder_test;
  logic clk = 1'b0;
  logic rst_n, atn_n, ifc_n, eoi_n, dav_n, ndac_pull, local_req, ext_trig, addr_wr, lf_term_en;
  logic listen, talk, remote, lockout, serial_poll, pp_enabled, trig, dev_clr, rx_valid, rx_end;
  logic [7:0] dio, rx_data, b;
  logic [4:0] addr_in, own_addr, a;
  logic [3:0] pp_resp;
  logic e;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 32'h4e00;
  // expected pulses {dev_clr, trig, rx_valid, rx_end, rx_data}
  logic [11:0] notes[$];

  always #5 clk = ~clk;

  gim_ctl_model i_gim_ctl_model (.clk(clk), .atn_n(atn_n), .ifc_n(ifc_n), .eoi_n(eoi_n),
    .dav_n(dav_n), .dio(dio), .ndac_pull(ndac_pull));

  gim_decoder i_gim_decoder (.clk(clk), .rst_n(rst_n), .atn_n(atn_n), .ifc_n(ifc_n),
    .eoi_n(eoi_n), .dav_n(dav_n), .dio(dio), .ndac_pull(ndac_pull), .local_req(local_req),
    .ext_trig(ext_trig), .addr_wr(addr_wr), .addr_in(addr_in), .lf_term_en(lf_term_en),
    .own_addr(own_addr), .listen(listen), .talk(talk), .remote(remote), .lockout(lockout),
    .serial_poll(serial_poll), .pp_enabled(pp_enabled), .pp_resp(pp_resp), .trig(trig),
    .dev_clr(dev_clr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cmd(input logic [6:0] code);
    i_gim_ctl_model.send(1'b1, 1'b0, {1'b0, code});
  endtask

  task automatic pin(input int which);
    @(posedge clk);
    local_req <= (which == 0);
    ext_trig <= (which != 0);
    repeat (5) @(posedge clk);
    local_req <= 1'b0;
    ext_trig <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic set_addr(input logic [4:0] v, input logic wr);
    @(posedge clk);
    addr_wr <= wr;
    addr_in <= v;
    @(posedge clk);
    addr_wr <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic done_test(input string name);
    chk(12'(notes.size()), 12'h000, "missing pulse");
    $display("test %s done", name);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // pulse watcher and timeout
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (rst_n && (dev_clr | trig | rx_valid) !== 1'b0)
      chk({dev_clr, trig, rx_valid, rx_valid & rx_end, rx_valid ? rx_data : 8'h00},
        notes.size() > 0 ? notes.pop_front() : 12'h000, "pulse");
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_errors++;
      conclude();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    local_req = 1'b0;
    ext_trig = 1'b0;
    addr_wr = 1'b0;
    addr_in = 5'h00;
    lf_term_en = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(12'(own_addr), 12'h014, "default address");
    chk(12'({listen, talk, remote, lockout, serial_poll, pp_enabled, ndac_pull}), 12'h001, "idle");
    done_test("reset");
    cmd(`GIM_CMD_GET);
    cmd(`GIM_CMD_GTR);
    cmd(`GIM_CMD_SDC);
    chk(12'(remote), 12'h000, "unaddressed go remote");
    notes.push_back(12'h800);
    cmd(`GIM_CMD_DCL);
    cmd(`GIM_CMD_LLO);
    chk(12'(lockout), 12'h001, "lockout");
    cmd(`GIM_CMD_SPE);
    chk(12'(serial_poll), 12'h001, "poll enable");
    cmd(`GIM_CMD_SPD);
    chk(12'(serial_poll), 12'h000, "poll disable");
    cmd(7'h1F);
    cmd(7'h0F);
    chk(12'({listen, talk, remote, lockout, serial_poll, pp_enabled, pp_resp}), 12'h040, "unlisted");
    done_test("universal");
    cmd(7'h34);
    chk(12'(listen), 12'h001, "listen");
    cmd(7'h54);
    chk(12'(talk), 12'h001, "own talk address");
    cmd(`GIM_CMD_GTR);
    chk(12'(remote), 12'h001, "go remote");
    pin(0);
    chk(12'(remote), 12'h001, "panel locked out");
    cmd(`GIM_CMD_GTL);
    chk(12'({remote, lockout}), 12'h000, "go local");
    cmd(`GIM_CMD_GTR);
    pin(0);
    chk(12'(remote), 12'h000, "panel local");
    notes.push_back(12'h800);
    cmd(`GIM_CMD_SDC);
    notes.push_back(12'h400);
    cmd(`GIM_CMD_GET);
    notes.push_back(12'h400);
    pin(1);
    cmd(`GIM_CMD_PPC);
    cmd(7'h6A);
    chk(12'({pp_enabled, pp_resp}), 12'h01A, "pp configure");
    cmd(`GIM_CMD_PPU);
    chk(12'(pp_enabled), 12'h000, "pp unconfigure");
    done_test("addressed");
    notes.push_back(12'h30A);
    i_gim_ctl_model.send(1'b0, 1'b0, 8'h0A);
    @(posedge clk);
    lf_term_en <= ~lf_term_en;
    notes.push_back(12'h20A);
    i_gim_ctl_model.send(1'b0, 1'b0, 8'h0A);
    notes.push_back(12'h30A);
    i_gim_ctl_model.send(1'b0, 1'b1, 8'h0A);
    notes.push_back(12'h214);
    i_gim_ctl_model.send(1'b0, 1'b0, 8'h14);
    i_gim_ctl_model.hold = 5;
    repeat (4)
    begin
      b = 8'($random(seed));
      e = 1'($random(seed));
      notes.push_back({3'b001, e, b});
      i_gim_ctl_model.send(1'b0, e, b);
    end
    i_gim_ctl_model.hold = 0;
    done_test("data");
    cmd(`GIM_CMD_SPE);
    i_gim_ctl_model.clear();
    chk(12'({listen, talk, serial_poll}), 12'h000, "interface clear");
    i_gim_ctl_model.send(1'b0, 1'b0, 8'h55);
    done_test("clear");
    set_addr(5'h1F, 1'b1);
    chk(12'(own_addr), 12'h014, "address 31 refused");
    set_addr(5'h03, 1'b0);
    chk(12'(own_addr), 12'h014, "address without strobe");
    a = 5'(($random(seed) & 32'h7FFFFFFF) % 31);
    set_addr(a, 1'b1);
    chk(own_addr, {7'h00, a}, "address set");
    cmd({2'b01, a});
    chk(12'(listen), 12'h001, "new listen address");
    cmd(`GIM_CMD_UNL);
    chk(12'(listen), 12'h000, "unlisten");
    done_test("address");
    conclude();
  end
endmodule

// ==== rtl/gim_decoder.sv ====
// interface message decoder: bus commands, addressing, remote/local, polls, trigger
`timescale 1ns/10ps
`include "gim_defs.svh"
module gim_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus pins; control lines active low, dio and ndac_pull active high
  input wire logic atn_n,
  input wire logic ifc_n,
  input wire logic eoi_n,
  input wire logic dav_n,
  input wire logic [7:0] dio,
  output logic ndac_pull,
  // front panel and trigger pins
  input wire logic local_req,
  input wire logic ext_trig,
  // settings from the host logic
  input wire logic addr_wr,
  input wire logic [4:0] addr_in,
  input wire logic lf_term_en,
  // state and events
  output logic [4:0] own_addr,
  output logic listen,
  output logic talk,
  output logic remote,
  output logic lockout,
  output logic serial_poll,
  output logic pp_enabled,
  output logic [3:0] pp_resp,
  output logic trig,
  output logic dev_clr,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end
);
  import gim_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [13:0] pins_s;
  logic atn_s;
  logic ifc_s;
  logic eoi_s;
  logic dav_s;
  logic loc_s;
  logic ext_s;
  logic [7:0] dio_s;

  // data is sampled through the same chain as dav; the talker settles it before dav falls
  // reset value is the idle level of each pin, so no false edge or clear follows reset
  gim_sync #(.W(14), .RST(14'h3C00)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({atn_n, ifc_n, eoi_n, dav_n, local_req, ext_trig, dio}),
    .q(pins_s)
  );
  assign {atn_s, ifc_s, eoi_s, dav_s, loc_s, ext_s, dio_s} = pins_s;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic is_group(input logic [6:0] c, input logic [1:0] g);
    is_group = (c[6:5] == g);
  endfunction

  gim_state_s r;
  gim_state_s next_r;
  logic take;
  logic take_cmd;
  logic take_data;
  logic [6:0] code;

  // a byte is taken on the falling edge of the synchronised data-valid
  assign take = r.dav_prev & ~dav_s;
  assign take_cmd = take & ~atn_s;
  assign take_data = take & atn_s;
  // bit 7 carries parity on some controllers, so commands ignore it
  assign code = dio_s[6:0];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.trig = 1'b0;
    next_r.dev_clr = 1'b0;
    next_r.rx_valid = 1'b0;
    next_r.dav_prev = dav_s;
    next_r.ext_prev = ext_s;
    // release ndac once a byte we care about is taken
    next_r.ndac_pull = dav_s & (~atn_s | r.listen);

    if (addr_wr && addr_in <= `GIM_ADDR_MAX)
      next_r.own_addr = addr_in;

    if (ext_s && !r.ext_prev)
      next_r.trig = 1'b1;

    // panel local only when not locked
    if (loc_s && r.rl == GIM_REMOTE)
      next_r.rl = GIM_LOCAL;

    if (take_cmd)
    begin
      // a parallel poll configure only qualifies the very next command byte
      next_r.pp_pend = 1'b0;
      case (code)
        `GIM_CMD_GTL:
        begin
          if (r.listen)
            next_r.rl = GIM_LOCAL;
        end
        `GIM_CMD_GTR:
        begin
          if (r.listen)
            next_r.rl = (r.rl == GIM_LOCAL_LOCK || r.rl == GIM_REMOTE_LOCK) ? GIM_REMOTE_LOCK : GIM_REMOTE;
        end
        `GIM_CMD_SDC:
        begin
          if (r.listen)
            next_r.dev_clr = 1'b1;
        end
        `GIM_CMD_PPC:
        begin
          if (r.listen)
            next_r.pp_pend = 1'b1;
        end
        `GIM_CMD_GET:
        begin
          if (r.listen)
            next_r.trig = 1'b1;
        end
        `GIM_CMD_LLO:
        begin
          if (r.rl == GIM_LOCAL)
            next_r.rl = GIM_LOCAL_LOCK;
          else if (r.rl == GIM_REMOTE)
            next_r.rl = GIM_REMOTE_LOCK;
        end
        `GIM_CMD_DCL:
        begin
          next_r.dev_clr = 1'b1;
        end
        `GIM_CMD_PPU:
        begin
          next_r.pp_enabled = 1'b0;
        end
        `GIM_CMD_SPE:
        begin
          next_r.serial_poll = 1'b1;
        end
        `GIM_CMD_SPD:
        begin
          next_r.serial_poll = 1'b0;
        end
        default:
        begin
          if (is_group(code, `GIM_GRP_LISTEN))
          begin
            if (code == `GIM_CMD_UNL)
              next_r.listen = 1'b0;
            else if (code[4:0] == r.own_addr)
              next_r.listen = 1'b1;
          end
          else if (is_group(code, `GIM_GRP_TALK))
          begin
            // another talker or untalk drops our talk state
            next_r.talk = (code[4:0] == r.own_addr);
          end
          else if (is_group(code, `GIM_GRP_SECOND) && r.pp_pend)
          begin
            next_r.pp_enabled = ~code[`GIM_SEC_PPD_BIT];
            if (!code[`GIM_SEC_PPD_BIT])
              next_r.pp_resp = code[3:0];
          end
        end
      endcase
    end
    else if (take_data && r.listen)
    begin
      next_r.rx_valid = 1'b1;
      next_r.rx_data = dio_s;
      next_r.rx_end = ~eoi_s | (lf_term_en & (dio_s == `GIM_CHAR_LF));
    end

    // clear line overrides bus traffic for listen, talk, serial poll, pending configure and received data
    if (!ifc_s)
    begin
      next_r.listen = 1'b0;
      next_r.talk = 1'b0;
      next_r.serial_poll = 1'b0;
      next_r.pp_pend = 1'b0;
      next_r.rx_valid = 1'b0;
    end

    next_r.remote = (next_r.rl == GIM_REMOTE) || (next_r.rl == GIM_REMOTE_LOCK);
    next_r.lockout = (next_r.rl == GIM_LOCAL_LOCK) || (next_r.rl == GIM_REMOTE_LOCK);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.rl <= GIM_LOCAL;
      r.own_addr <= `GIM_ADDR_DEF;
      r.dav_prev <= 1'b1;
      r.ndac_pull <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign own_addr = r.own_addr;
  assign listen = r.listen;
  assign talk = r.talk;
  assign remote = r.remote;
  assign lockout = r.lockout;
  assign serial_poll = r.serial_poll;
  assign pp_enabled = r.pp_enabled;
  assign pp_resp = r.pp_resp;
  assign trig = r.trig;
  assign dev_clr = r.dev_clr;
  assign rx_valid = r.rx_valid;
  assign rx_data = r.rx_data;
  assign rx_end = r.rx_end;
  assign ndac_pull = r.ndac_pull;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_data_no_cmd;
    take_data && !ext_s |=> !dev_clr && !trig;
  endproperty
  a_data_no_cmd: assert property (p_data_no_cmd) else $error("data byte acted as command");

  property p_dcl;
    take_cmd && code == `GIM_CMD_DCL |=> dev_clr ##1 !dev_clr;
  endproperty
  a_dcl: assert property (p_dcl) else $error("device clear not one pulse");

  property p_sdc;
    take_cmd && code == `GIM_CMD_SDC |=> dev_clr == $past(r.listen);
  endproperty
  a_sdc: assert property (p_sdc) else $error("selected clear wrong for listen state");

  property p_get_unaddr;
    take_cmd && code == `GIM_CMD_GET && !listen && !(ext_s && !r.ext_prev) |=> !trig;
  endproperty
  a_get_unaddr: assert property (p_get_unaddr) else $error("trigger while not listening");

  property p_get;
    take_cmd && code == `GIM_CMD_GET && listen |=> trig;
  endproperty
  a_get: assert property (p_get) else $error("group trigger missed");

  property p_ifc;
    !ifc_s |=> !listen && !talk && !serial_poll;
  endproperty
  a_ifc: assert property (p_ifc) else $error("clear line left bus state");

  property p_llo;
    take_cmd && code == `GIM_CMD_LLO ##1 (!(take_cmd && code == `GIM_CMD_GTL && listen)) [*3] |-> lockout;
  endproperty
  a_llo: assert property (p_llo) else $error("lockout lost without go-local");

  property p_lock_panel;
    lockout && remote && loc_s && !take_cmd |=> remote;
  endproperty
  a_lock_panel: assert property (p_lock_panel) else $error("panel local worked under lockout");

  property p_spoll;
    take_cmd && ifc_s && (code == `GIM_CMD_SPE || code == `GIM_CMD_SPD) |=> serial_poll == ($past(code) == `GIM_CMD_SPE);
  endproperty
  a_spoll: assert property (p_spoll) else $error("serial poll state wrong");

  property p_ppu;
    take_cmd && code == `GIM_CMD_PPU |=> !pp_enabled;
  endproperty
  a_ppu: assert property (p_ppu) else $error("parallel poll not ended");

  property p_gtl;
    take_cmd && code == `GIM_CMD_GTL && listen |=> !remote && !lockout;
  endproperty
  a_gtl: assert property (p_gtl) else $error("go-local not taken");

  property p_gtr;
    take_cmd && code == `GIM_CMD_GTR && listen |=> remote;
  endproperty
  a_gtr: assert property (p_gtr) else $error("go-remote not taken");

  property p_addr;
    addr_wr && addr_in > `GIM_ADDR_MAX |=> own_addr == $past(own_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("out of range address accepted");

  property p_term;
    take_data && listen && ifc_s && eoi_s |=> rx_valid && rx_end == ($past(lf_term_en) && rx_data == `GIM_CHAR_LF);
  endproperty
  a_term: assert property (p_term) else $error("terminator decision wrong");

  property p_unlisted;
    take_cmd && ifc_s && !loc_s && code == 7'h1F |=> $stable(listen) && $stable(remote) && $stable(serial_poll) && !dev_clr;
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted code changed state");

  c_listen_data: cover property (take_data && listen ##1 rx_valid && rx_end);
  c_get: cover property (take_cmd && code == `GIM_CMD_GET && listen ##1 trig);
  c_lock: cover property (lockout && remote ##[1:200] !lockout);
  c_pp: cover property (pp_enabled);
endmodule

// ==== rtl/gim_defs.svh ====
// bus command codes, address limits and reset values for the interface message decoder
`ifndef GIM_DEFS_SVH
`define GIM_DEFS_SVH

// ----------------------------------------
// addressed commands
// ----------------------------------------
`define GIM_CMD_GTL 7'h01
`define GIM_CMD_GTR 7'h02
`define GIM_CMD_SDC 7'h04
`define GIM_CMD_PPC 7'h05
`define GIM_CMD_GET 7'h08

// ----------------------------------------
// universal commands
// ----------------------------------------
`define GIM_CMD_LLO 7'h11
`define GIM_CMD_DCL 7'h14
`define GIM_CMD_PPU 7'h15
`define GIM_CMD_SPE 7'h18
`define GIM_CMD_SPD 7'h19

// ----------------------------------------
// address groups
// ----------------------------------------
`define GIM_GRP_LISTEN 2'h1
`define GIM_GRP_TALK 2'h2
`define GIM_GRP_SECOND 2'h3
`define GIM_CMD_UNL 7'h3F
`define GIM_SEC_PPD_BIT 4
`define GIM_ADDR_MAX 5'h1E
`define GIM_ADDR_DEF 5'h14

// ----------------------------------------
// data terminator
// ----------------------------------------
`define GIM_CHAR_LF 8'h0A

`endif

// ==== rtl/gim_pkg.sv ====
// types shared by the interface message decoder
package gim_pkg;

  // remote/local state of the instrument
  typedef enum logic [1:0] {
    GIM_LOCAL,
    GIM_REMOTE,
    GIM_LOCAL_LOCK,
    GIM_REMOTE_LOCK
  } gim_rl_e;

  typedef struct packed {
    gim_rl_e rl;
    logic remote;
    logic lockout;
    logic listen;
    logic talk;
    logic serial_poll;
    logic pp_pend;
    logic pp_enabled;
    logic [3:0] pp_resp;
    logic trig;
    logic dev_clr;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_end;
    logic [4:0] own_addr;
    logic dav_prev;
    logic ext_prev;
    logic ndac_pull;
  } gim_state_s;

endpackage

// ==== rtl/gim_sync.sv ====
// two-flop synchroniser for bus pins and other asynchronous inputs
`timescale 1ns/10ps
module gim_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous input and synchronised output
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= RST;
      q <= RST;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
